// ===== inc/trm_pkg.sv
// Package: constants, state types and register map of the tape read monitor
package trm_pkg;

  localparam int unsigned CLK_HZ          = 20000000;
  // Marker debounce delay in microseconds
  localparam int unsigned MARKER_DELAY_US = 20;
  localparam int unsigned MARKER_DELAY_CYC =
    (MARKER_DELAY_US * CLK_HZ + 999999) / 1000000;
  // Inter-character gap timeout in microseconds
  localparam int unsigned CHAR_GAP_US     = 60;
  localparam int unsigned CHAR_GAP_CYC    = (CHAR_GAP_US * CLK_HZ) / 1000000;
  // File finder timeout in tenths of a millisecond (31.5 ms)
  localparam int unsigned FILE_GAP_TENTH_MS = 315;
  localparam int unsigned FILE_GAP_CYC =
    (FILE_GAP_TENTH_MS * (CLK_HZ / 1000)) / 10;

  localparam logic [3:0] MARK_RECORD_CNT = 4'h4;
  localparam logic [3:0] MARK_FILE_CNT   = 4'h8;
  localparam logic [3:0] BIT_CLEAR_CNT   = 4'h4;
  localparam logic [3:0] BIT_BYTE_CNT    = 4'h8;

  // Register byte offsets on the Wishbone bus
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK   = 4'h8;
  localparam logic [3:0] REG_DATA   = 4'hc;

  // Control register bits
  localparam int unsigned CTRL_FIND_GAPS = 0;
  localparam int unsigned CTRL_FILE_FIND = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;

  // Event bits in status and mask
  localparam int unsigned EV_BYTE   = 0;
  localparam int unsigned EV_RECORD = 1;
  localparam int unsigned EV_FILE   = 2;
  localparam int unsigned EV_GAP    = 3;
  localparam int unsigned EV_START  = 4;
  localparam int unsigned EV_END    = 5;
  localparam int unsigned EV_W      = 6;
  localparam logic [5:0]  MASK_RESET = 6'h00;

  typedef enum logic [1:0] {
    TRM_BUS_IDLE = 2'b01,
    TRM_BUS_ACK  = 2'b10
  } trm_bus_st_t;

endpackage

// ===== inc/trm_timer_if.sv
// Interface carrying trigger and status of one retriggerable timer
`timescale 1ns/1ns
interface trm_timer_if;
  logic trig;
  logic run;
  logic expire;
  modport owner (output trig, input run, input expire);
  modport timer (input trig, output run, output expire);
endinterface

// ===== rtl/trm_retrig_timer.sv
// Retriggerable one-shot counter on the system clock
`timescale 1ns/1ns
module trm_retrig_timer #(
  parameter int unsigned COUNT = 16,
  parameter int unsigned W     = 16
) (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   hold_i,
  trm_timer_if.timer  tmr
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         expire;
  } trm_tmr_st_t;

  trm_tmr_st_t st_q;
  trm_tmr_st_t st_d;

  always_comb begin
    st_d        = st_q;
    st_d.expire = 1'b0;
    if (hold_i) begin
      st_d.cnt = '0;
      st_d.run = 1'b0;
    end else if (tmr.trig) begin
      st_d.cnt = W'(COUNT - 1);
      st_d.run = 1'b1;
    end else if (st_q.run) begin
      if (st_q.cnt == '0) begin
        st_d.run    = 1'b0;
        st_d.expire = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tmr.run    = st_q.run;
  assign tmr.expire = st_q.expire;
endmodule

// ===== rtl/trm_marker_filter.sv
// Debounce and delay filter for one tape position marker
`timescale 1ns/1ns
module trm_marker_filter #(
  parameter int unsigned DELAY = 400,
  parameter int unsigned W     = 10
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output logic      clean_o,
  output logic      rise_o
);
  typedef struct packed {
    logic [1:0]   sync;
    logic [W-1:0] cnt;
    logic         clean;
    logic         rise;
  } trm_flt_st_t;

  trm_flt_st_t st_q;
  trm_flt_st_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.sync = {st_q.sync[0], raw_i};
    st_d.rise = 1'b0;
    if (st_q.sync[1] == st_q.clean) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == W'(DELAY - 1)) begin
      st_d.cnt   = '0;
      st_d.clean = st_q.sync[1];
      st_d.rise  = st_q.sync[1];
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign clean_o = st_q.clean;
  assign rise_o  = st_q.rise;
endmodule

// ===== rtl/trm_tape_read_monitor.sv
// Tape read monitor: gap, mark, byte and file-gap detection with Wishbone registers
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - Debounce markers, pass on after 20 us
// - Each clean marker sets its own flag
// - Gap timer retriggered by each bit clock while find gaps is set
// - 60 us without clocks ends a gap period
// - Mark count four raises record mark
// - Mark count eight raises file mark
// - Mark count cleared by bits or enable low
// - Bit counter counts only while gap timer runs
// - Bit count four clears mark counter
// - Bit count eight raises byte ready
// - Gap timer expiry clears bit counter
// - Bit count eight retriggers 31.5 ms finder
// - Finder expiry raises file gap found
// - Each detection raises an interrupt event
// - Serial read bits deserialised into bytes
module trm_tape_read_monitor
  import trm_pkg::*;
#(
  parameter int unsigned FILE_GAP_COUNT = FILE_GAP_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        recovered_bit_clock_i,
  input  wire logic        read_data_i,
  input  wire logic        tape_start_marker_i,
  input  wire logic        tape_end_marker_i,
  output logic             tape_start_seen_o,
  output logic             tape_end_seen_o,
  output logic             record_mark_seen_o,
  output logic             file_mark_seen_o,
  output logic             byte_ready_o,
  output logic             file_gap_found_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [2:0]        clk_sync;
    logic [1:0]        dat_sync;
    logic [7:0]        shift;
    logic [7:0]        data;
    logic [3:0]        bit_cnt;
    logic [3:0]        mark_cnt;
    logic              record_mark;
    logic              file_mark;
    logic              byte_ready;
    logic              file_gap;
    logic [1:0]        ctrl;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic              irq;
    logic              start_seen;
    logic              end_seen;
    trm_bus_st_t       bus;
    logic              ack;
    logic [31:0]       rdat;
  } trm_st_t;

  trm_st_t st_q;
  trm_st_t st_d;

  trm_timer_if gap_tmr ();
  trm_timer_if file_tmr ();

  logic start_clean;
  logic start_rise;
  logic end_clean;
  logic end_rise;
  logic bit_edge;
  logic find_gaps;
  logic finder_on;
  logic bus_req;
  logic wr_fire;
  logic [EV_W-1:0] ev;

  trm_marker_filter #(
    .DELAY (MARKER_DELAY_CYC),
    .W     (10)
  ) u_start_flt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (tape_start_marker_i),
    .clean_o (start_clean),
    .rise_o  (start_rise)
  );

  trm_marker_filter #(
    .DELAY (MARKER_DELAY_CYC),
    .W     (10)
  ) u_end_flt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (tape_end_marker_i),
    .clean_o (end_clean),
    .rise_o  (end_rise)
  );

  trm_retrig_timer #(
    .COUNT (CHAR_GAP_CYC),
    .W     (12)
  ) u_gap_tmr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .hold_i (1'b0),
    .tmr    (gap_tmr.timer)
  );

  trm_retrig_timer #(
    .COUNT (FILE_GAP_COUNT),
    .W     (20)
  ) u_file_tmr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .hold_i (!finder_on),
    .tmr    (file_tmr.timer)
  );

  // bit clock edge after two sync stages
  assign bit_edge  = st_q.clk_sync[1] & ~st_q.clk_sync[2];
  assign find_gaps = st_q.ctrl[CTRL_FIND_GAPS];
  assign finder_on = st_q.ctrl[CTRL_FILE_FIND];

  // each bit clock retriggers the gap timer while enabled, the finder only on bit count eight
  assign gap_tmr.trig  = bit_edge & find_gaps;
  assign file_tmr.trig = bit_edge & gap_tmr.run & (st_q.bit_cnt == BIT_BYTE_CNT - 4'h1);

  assign bus_req = wb_cyc_i & wb_stb_i;
  // Write lands at the edge where the master samples ack high
  assign wr_fire = bus_req & wb_we_i & (st_q.bus == TRM_BUS_ACK);

  always_comb begin
    st_d          = st_q;
    st_d.clk_sync = {st_q.clk_sync[1:0], recovered_bit_clock_i};
    st_d.dat_sync = {st_q.dat_sync[0], read_data_i};
    ev            = '0;

    // shift serial bits on each bit clock
    if (bit_edge) begin
      st_d.shift = {st_q.shift[6:0], st_q.dat_sync[1]};
    end

    // bit counter counts while timer runs
    if (bit_edge && gap_tmr.run) begin
      st_d.bit_cnt = st_q.bit_cnt + 4'h1;
      if (st_q.bit_cnt == BIT_BYTE_CNT - 4'h1) begin
        st_d.bit_cnt    = '0;
        st_d.byte_ready = 1'b1;
        st_d.data       = {st_q.shift[6:0], st_q.dat_sync[1]};
        ev[EV_BYTE]     = 1'b1;
      end
    end else if (bit_edge) begin
      st_d.byte_ready = 1'b0;
    end

    if (gap_tmr.expire) begin
      st_d.bit_cnt = '0;
      st_d.mark_cnt = st_q.mark_cnt + 4'h1;
      if (st_q.mark_cnt + 4'h1 == MARK_RECORD_CNT) begin
        st_d.record_mark = 1'b1;
        ev[EV_RECORD]    = 1'b1;
      end
      if (st_q.mark_cnt + 4'h1 == MARK_FILE_CNT) begin
        st_d.file_mark = 1'b1;
        ev[EV_FILE]    = 1'b1;
      end
    end

    // clear on bit count four or enable low
    // a character clears the count, but its trailing gap counts as one mark
    if (!find_gaps ||
        (bit_edge && gap_tmr.run && st_q.bit_cnt == BIT_CLEAR_CNT - 4'h1)) begin
      st_d.mark_cnt    = '0;
      st_d.record_mark = 1'b0;
      st_d.file_mark   = 1'b0;
    end
    if (!find_gaps) begin
      st_d.bit_cnt = '0;
    end

    // finder expiry flags a file gap
    if (file_tmr.expire) begin
      st_d.file_gap = 1'b1;
      ev[EV_GAP]    = 1'b1;
    end else if (file_tmr.trig || !finder_on) begin
      st_d.file_gap = 1'b0;
    end

    // each marker sets its own flag
    st_d.start_seen = start_clean;
    st_d.end_seen   = end_clean;
    ev[EV_START]    = start_rise;
    ev[EV_END]      = end_rise;

    // Wishbone slave, one wait state then ack
    st_d.ack = 1'b0;
    case (st_q.bus)
      TRM_BUS_IDLE: begin
        if (bus_req) begin
          st_d.ack = 1'b1;
          st_d.bus = TRM_BUS_ACK;
          case (wb_adr_i)
            REG_CTRL:   st_d.rdat = {30'h0, st_q.ctrl};
            REG_STATUS: st_d.rdat = {26'h0, st_q.status};
            REG_MASK:   st_d.rdat = {26'h0, st_q.mask};
            REG_DATA:   st_d.rdat = {24'h0, st_q.data};
            default:    st_d.rdat = 32'h0;
          endcase
        end
      end
      TRM_BUS_ACK: begin
        st_d.bus = TRM_BUS_IDLE;
      end
      default: begin
        st_d.bus = TRM_BUS_IDLE;
      end
    endcase

    if (wr_fire && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) begin
        st_d.ctrl = wb_dat_i[1:0];
      end
      if (wb_adr_i == REG_MASK) begin
        st_d.mask = wb_dat_i[EV_W-1:0];
      end
    end

    // sticky events, set wins over clear
    if (wr_fire && wb_sel_i[0] && wb_adr_i == REG_STATUS) begin
      st_d.status = (st_q.status & ~wb_dat_i[EV_W-1:0]) | ev;
    end else begin
      st_d.status = st_q.status | ev;
    end
    st_d.irq = |(st_d.status & st_d.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q        <= '0;
      st_q.ctrl   <= CTRL_RESET;
      st_q.mask   <= MASK_RESET;
      st_q.bus    <= TRM_BUS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o           = st_q.rdat;
  assign wb_ack_o           = st_q.ack;
  assign tape_start_seen_o  = st_q.start_seen;
  assign tape_end_seen_o    = st_q.end_seen;
  assign record_mark_seen_o = st_q.record_mark;
  assign file_mark_seen_o   = st_q.file_mark;
  assign byte_ready_o       = st_q.byte_ready;
  assign file_gap_found_o   = st_q.file_gap;
  assign irq_o              = st_q.irq;
endmodule

// ===== bench/trm_tape_read_monitor_chk.sv
// Port checker for the tape read monitor
`timescale 1ns/1ns
module trm_tape_read_monitor_chk
  import trm_pkg::*;
#(
  parameter int unsigned FILE_GAP_COUNT = FILE_GAP_CYC
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        recovered_bit_clock_i,
  input wire logic        tape_start_marker_i,
  input wire logic        tape_start_seen_o,
  input wire logic        record_mark_seen_o,
  input wire logic        file_mark_seen_o,
  input wire logic        byte_ready_o,
  input wire logic        file_gap_found_o
);
  logic [19:0] idle_q;
  logic [9:0]  run_q;
  // Cycles since bit clock high, cycles of marker high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_q <= 20'h0;
      run_q  <= 10'h0;
    end else begin
      idle_q <= recovered_bit_clock_i ? 20'h0 : idle_q + {19'h0, ~&idle_q};
      run_q  <= tape_start_marker_i ? run_q + {9'h0, ~&run_q} : 10'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_dat_hold; $changed(wb_dat_o) |-> wb_ack_o; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved outside ack");
  property p_byte_edge; $rose(byte_ready_o) |-> idle_q < 20'd8; endproperty
  a_byte_edge: assert property (p_byte_edge) else $error("byte ready without bit edge");
  property p_rec_gap;
    $rose(record_mark_seen_o) |-> idle_q >= CHAR_GAP_CYC - 8 && idle_q <= CHAR_GAP_CYC + 8;
  endproperty
  a_rec_gap: assert property (p_rec_gap) else $error("record mark off gap expiry");
  property p_file_gap;
    $rose(file_mark_seen_o) |-> idle_q >= CHAR_GAP_CYC - 8 && idle_q <= CHAR_GAP_CYC + 8;
  endproperty
  a_file_gap: assert property (p_file_gap) else $error("file mark off gap expiry");
  property p_finder;
    $rose(file_gap_found_o) |-> idle_q >= FILE_GAP_COUNT - 8 && idle_q <= FILE_GAP_COUNT + 8;
  endproperty
  a_finder: assert property (p_finder) else $error("file gap found off timeout");
  property p_marker;
    $rose(tape_start_seen_o) |-> run_q >= MARKER_DELAY_CYC && run_q <= MARKER_DELAY_CYC + 8;
  endproperty
  a_marker: assert property (p_marker) else $error("marker passed off delay");
endmodule
bind trm_tape_read_monitor trm_tape_read_monitor_chk #(.FILE_GAP_COUNT(FILE_GAP_COUNT)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .recovered_bit_clock_i(recovered_bit_clock_i),
  .tape_start_marker_i(tape_start_marker_i), .tape_start_seen_o(tape_start_seen_o),
  .record_mark_seen_o(record_mark_seen_o), .file_mark_seen_o(file_mark_seen_o),
  .byte_ready_o(byte_ready_o), .file_gap_found_o(file_gap_found_o));

// ===== bench/trm_head_model.sv
// Head board model: bit clock, serial data and position markers
`timescale 1ns/1ns
module trm_head_model (
  output logic bit_clk_o,
  output logic data_o,
  output logic start_o,
  output logic end_o
);
  initial begin
    bit_clk_o = 1'b0;
    data_o = 1'b0;
    start_o = 1'b0;
    end_o = 1'b0;
  end
  // Bit clock stands low between frames
  task automatic bit_out(input logic b);
    data_o = b;
    #200 bit_clk_o = 1'b1;
    #200 bit_clk_o = 1'b0;
  endtask
  // starting edge, then eight bits MSB first
  task automatic send_byte(input logic [7:0] b);
    #7;
    bit_out(1'b0);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    data_o = ~b[0];
  endtask
  // lone edge between gaps of a mark
  task automatic pulse();
    #7;
    bit_out(1'b0);
    data_o = 1'b1;
  endtask
  task automatic bounce(input logic sel, input logic lvl);
    #7;
    for (int i = 0; i < 6; i++) begin
      #1000;
      if (sel) end_o = ~end_o;
      else start_o = ~start_o;
    end
    #1000;
    if (sel) end_o = lvl;
    else start_o = lvl;
  endtask
endmodule

// ===== bench/tb_tape_read_monitor.sv
// Testbench for the tape read monitor
`timescale 1ns/1ns
module tb_tape_read_monitor
  import trm_pkg::*;
();
  localparam int unsigned GAP = 2000;
  logic        clk_i, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, bclk, rdat, sm, em;
  logic        s_seen, e_seen, rec, fil, brdy, fgap, irq;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat_o;
  int          errors = 0, samples_checked = 0, cyc_cnt = 0;
  trm_tape_read_monitor #(.FILE_GAP_COUNT(GAP)) u_trm_tape_read_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack),
    .recovered_bit_clock_i(bclk), .read_data_i(rdat), .tape_start_marker_i(sm),
    .tape_end_marker_i(em), .tape_start_seen_o(s_seen), .tape_end_seen_o(e_seen),
    .record_mark_seen_o(rec), .file_mark_seen_o(fil), .byte_ready_o(brdy),
    .file_gap_found_o(fgap), .irq_o(irq));
  trm_head_model u_trm_head_model (.bit_clk_o(bclk), .data_o(rdat), .start_o(sm), .end_o(em));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int t = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && t < 50) begin
      t++;
      @(posedge clk_i);
    end
    if (t == 50) errors++;
    q = rdat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic t_regs();
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_MASK, 32'h0);
    rd_chk(REG_STATUS, 32'h0);
    wr(4'h2, 32'hff);
    rd_chk(4'h2, 32'h0);
    wr(REG_MASK, 32'hff);
    rd_chk(REG_MASK, 32'h3f);
  endtask
  task automatic t_byte();
    wr(REG_MASK, 32'h1);
    wr(REG_CTRL, 32'h1);
    u_trm_head_model.send_byte(8'ha5);
    wait_clk(2);
    chkb(brdy, 1'b1);
    chkb(irq, 1'b1);
    rd_chk(REG_DATA, 32'ha5);
    rd_chk(REG_STATUS, 32'h1);
    wr(REG_MASK, 32'h0);
    chkb(irq, 1'b0);
    wr(REG_MASK, 32'h1);
    chkb(irq, 1'b1);
    wr(REG_STATUS, 32'h1);
    chkb(irq, 1'b0);
    wait_clk(1400);
    chkb(rec, 1'b0);
  endtask
  task automatic t_marks();
    for (int i = 2; i <= 8; i++) begin
      u_trm_head_model.pulse();
      wait_clk(1400);
      chkb(rec, i >= 4);
      chkb(fil, i == 8);
    end
    u_trm_head_model.send_byte(8'h3c);
    wait_clk(2);
    chkb(rec, 1'b0);
    chkb(fil, 1'b0);
    rd_chk(REG_STATUS, 32'h7);
    wr(REG_STATUS, 32'h3f);
    wait_clk(1400);
    for (int i = 0; i < 3; i++) begin
      u_trm_head_model.pulse();
      wait_clk(1400);
    end
    chkb(rec, 1'b1);
    wr(REG_CTRL, 32'h0);
    wait_clk(1);
    chkb(rec, 1'b0);
  endtask
  task automatic t_finder();
    wr(REG_STATUS, 32'h3f);
    wr(REG_CTRL, 32'h3);
    u_trm_head_model.send_byte(8'h81);
    wait_clk(GAP - 100);
    chkb(fgap, 1'b0);
    wait_clk(200);
    chkb(fgap, 1'b1);
    rd_chk(REG_STATUS, 32'h9);
    wr(REG_CTRL, 32'h1);
    wait_clk(1);
    chkb(fgap, 1'b0);
    u_trm_head_model.send_byte(8'h81);
    wait_clk(GAP + 100);
    chkb(fgap, 1'b0);
  endtask
  task automatic t_markers();
    wr(REG_STATUS, 32'h3f);
    u_trm_head_model.bounce(1'b0, 1'b1);
    wait_clk(MARKER_DELAY_CYC - 20);
    chkb(s_seen, 1'b0);
    wait_clk(40);
    chkb(s_seen, 1'b1);
    u_trm_head_model.bounce(1'b1, 1'b1);
    wait_clk(MARKER_DELAY_CYC + 20);
    chkb(e_seen, 1'b1);
    rd_chk(REG_STATUS, 32'h30);
  endtask
  initial begin
    wait_clk(8);
    rst_i <= 1'b0;
    t_regs();
    t_byte();
    t_marks();
    t_finder();
    t_markers();
    summarize();
  end
endmodule
